// File: shared/ldac_params.svh
// Constants for the destination address classifier
`ifndef LDAC_PARAMS_SVH
`define LDAC_PARAMS_SVH
`define LDAC_IND_LO 7'h04
`define LDAC_IND_HI 7'h5F
`define LDAC_GRP_LO 7'h60
`define LDAC_GRP_HI 7'h7D
`define LDAC_MARK32 7'h7E
`define LDAC_GLOBAL 7'h7F
`define LDAC_RESERVED 7'h00
`define LDAC_SPEC3 7'h03
`define LDAC_IND32_LO 32'h00000080
`define LDAC_MAX_ADDR 5'h10
`define LDAC_OCT32 3'h4
`endif

// File: shared/ldac_pkg.sv
// Types for the destination address classifier
package ldac_pkg;
  typedef enum logic [2:0]
  {
    LDAC_CL_RSVD = 3'h0,
    LDAC_CL_SPEC = 3'h1,
    LDAC_CL_SPEC3 = 3'h2,
    LDAC_CL_IND = 3'h3,
    LDAC_CL_GRP = 3'h4,
    LDAC_CL_GLOB = 3'h5
  } ldac_class_t;
  typedef enum logic [1:0]
  {
    LDAC_ST_IDLE = 2'h0,
    LDAC_ST_OCT = 2'h1,
    LDAC_ST_LONG = 2'h3,
    LDAC_ST_DONE = 2'h2
  } ldac_state_t;
endpackage

// File: shared/ldac_addr_if.sv
// Carrier for one completed destination address
`timescale 1ns/100ps
`default_nettype none
interface ldac_addr_if;
  logic vld;
  ldac_pkg::ldac_class_t cls;
  logic [31:0] value;
  modport src (output vld, output cls, output value);
  modport dst (input vld, input cls, input value);
endinterface
`default_nettype wire

// File: design/ldac_classify.sv
// Classifies one address value by range
`timescale 1ns/100ps
`default_nettype none
`include "ldac_params.svh"
module ldac_classify
  import ldac_pkg::*;
(
  input wire logic i_long,
  input wire logic [31:0] i_value,
  output ldac_class_t o_cls
);
  logic [6:0] v7;
  assign v7 = i_value[6:0];
  // ------------------------------------------------
  // Range decode
  // ------------------------------------------------
  // Short and long share group, global and special codes
  always_comb
  begin
    if (i_long && i_value >= `LDAC_IND32_LO)
      o_cls = LDAC_CL_IND;
    else if (v7 == `LDAC_GLOBAL)
      o_cls = LDAC_CL_GLOB;
    else if (v7 >= `LDAC_GRP_LO && v7 <= `LDAC_GRP_HI)
      o_cls = LDAC_CL_GRP;
    else if (!i_long && v7 >= `LDAC_IND_LO && v7 <= `LDAC_IND_HI)
      o_cls = LDAC_CL_IND;
    else if (v7 == `LDAC_RESERVED)
      o_cls = LDAC_CL_RSVD;
    else if (v7 == `LDAC_SPEC3)
      o_cls = LDAC_CL_SPEC3;
    else
      o_cls = LDAC_CL_SPEC;
  end
endmodule
`default_nettype wire

// File: design/ldac_parser.sv
// Octet parser assembling destination addresses
`timescale 1ns/100ps
`default_nettype none
`include "ldac_params.svh"
module ldac_parser
  import ldac_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_start,
  input wire logic i_oct_vld,
  input wire logic [7:0] i_oct,
  output logic o_last,
  ldac_addr_if.src addr
);
  ldac_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [31:0] acc_q, acc_d;
  logic ext_q, ext_d;
  logic vld_d, long_d;
  logic [31:0] val_d;
  logic vld_q, long_q, last_q;
  logic [31:0] val_q;
  logic last_d;
  ldac_class_t cls_w;
  ldac_classify u_cls
  (
    .i_long(long_q),
    .i_value(val_q),
    .o_cls(cls_w)
  );
  // ------------------------------------------------
  // Octet walk
  // ------------------------------------------------
  // Marker 126 opens four value octets; extension bit sits in bit 0
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    acc_d = acc_q;
    ext_d = ext_q;
    vld_d = 1'b0;
    long_d = long_q;
    val_d = val_q;
    last_d = 1'b0;
    case (state_q)
      LDAC_ST_IDLE:
        if (i_start)
          state_d = LDAC_ST_OCT;
      LDAC_ST_OCT:
        if (i_oct_vld)
        begin
          if (i_oct[7:1] == `LDAC_MARK32)
          begin
            state_d = LDAC_ST_LONG;
            cnt_d = 3'h0;
            ext_d = i_oct[0];
          end
          else
          begin
            vld_d = 1'b1;
            long_d = 1'b0;
            val_d = {25'h0, i_oct[7:1]};
            if (i_oct[0])
            begin
              last_d = 1'b1;
              state_d = LDAC_ST_DONE;
            end
          end
        end
      LDAC_ST_LONG:
        if (i_oct_vld)
        begin
          acc_d = {acc_q[23:0], i_oct};
          cnt_d = cnt_q + 3'h1;
          if (cnt_q + 3'h1 == `LDAC_OCT32)
          begin
            vld_d = 1'b1;
            long_d = 1'b1;
            val_d = {acc_q[23:0], i_oct};
            if (ext_q)
            begin
              last_d = 1'b1;
              state_d = LDAC_ST_DONE;
            end
            else
              state_d = LDAC_ST_OCT;
          end
        end
      LDAC_ST_DONE:
        state_d = i_start ? LDAC_ST_OCT : LDAC_ST_IDLE;
      default:
        state_d = LDAC_ST_IDLE;
    endcase
    if (i_start)
      state_d = LDAC_ST_OCT;
  end
  // Register stage
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      state_q <= LDAC_ST_IDLE;
      cnt_q <= 3'h0;
      acc_q <= 32'h0;
      ext_q <= 1'b0;
      vld_q <= 1'b0;
      long_q <= 1'b0;
      val_q <= 32'h0;
      last_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      ext_q <= ext_d;
      vld_q <= vld_d;
      long_q <= long_d;
      val_q <= val_d;
      last_q <= last_d;
    end
  end
  assign addr.vld = vld_q;
  assign addr.cls = cls_w;
  assign addr.value = val_q;
  assign o_last = last_q;
endmodule
`default_nettype wire

// File: design/ldac_top.sv
// Destination address field classifier for a receiving station
`timescale 1ns/100ps
`default_nettype none
`include "ldac_params.svh"
// Overview of operation
// - Single octet values 4 to 95 are individual addresses.
// - Four octet values 128 and up are individual addresses.
// - One to sixteen individual destinations accepted per frame.
// - All addresses consumed and searched for own individual address.
// - Values 96 to 125 are group multicast addresses.
// - Group addresses always recognised on receive.
// - Without group support, group addresses are skipped, frame kept.
// - With group support, one to sixteen group addresses accepted.
// - Group addressed frames never get coupled final-bit acknowledgement.
// - Joined-group TEST command gets uncoupled TEST response, final zero.
// - Mixed multicast, special and individual fields are handled.
// - Any station receives mixed address fields correctly.
// - Normal acknowledgement handling applies to mixed fields without multicast.
// - At most sixteen addresses in a field, all types counted.
// - In mixed fields only individual and special addresses acknowledged.
// - Multicast not acknowledged; TEST response allowed for poll zero.
// - Seven-bit all ones is the global address in both formats.
// - Zero destination value is reserved and skipped.
// - Field ends with the address whose first octet has extension bit one.
module ldac_top
  import ldac_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  input wire logic i_frame_start,
  input wire logic i_oct_vld,
  input wire logic [7:0] i_oct,
  input wire logic [31:0] i_own_addr,
  input wire logic i_own_long,
  input wire logic i_grp_enable,
  input wire logic [29:0] i_grp_joined,
  input wire logic i_is_test_cmd,
  input wire logic i_poll_bit,
  output logic o_done,
  output logic o_own_match,
  output logic o_grp_match,
  output logic o_glob_match,
  output logic o_ack_ok,
  output logic o_test_rsp,
  output logic o_rsp_final,
  output logic o_violation,
  output logic [4:0] o_addr_cnt
);
  ldac_addr_if a_if ();
  logic last_w;
  ldac_parser u_parser
  (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_start(i_frame_start),
    .i_oct_vld(i_oct_vld),
    .i_oct(i_oct),
    .o_last(last_w),
    .addr(a_if)
  );
  // ------------------------------------------------
  // Per-frame accumulation
  // ------------------------------------------------
  logic [4:0] cnt_q, cnt_d;
  logic own_q, own_d, grp_q, grp_d, glob_q, glob_d;
  logic seen_grp_q, seen_grp_d, seen_mc_q, seen_mc_d, seen3_q, seen3_d;
  logic viol_q, viol_d;
  logic done_q, done_d;
  logic ack_q, ack_d, test_q, test_d;
  logic is_mc;
  logic own_hit;
  logic [4:0] gidx;
  // Multicast means group or global
  assign is_mc = (a_if.cls == LDAC_CL_GRP) || (a_if.cls == LDAC_CL_GLOB);
  // Format must agree too, so a short 4 never matches a long own address
  assign own_hit = (a_if.cls == LDAC_CL_IND) && (a_if.value == i_own_addr) &&
                   (a_if.value >= `LDAC_IND32_LO ? i_own_long : !i_own_long);
  // Member index from the seven-bit value, cut to the reach of the joined vector
  assign gidx = 5'(a_if.value[6:0] - `LDAC_GRP_LO);
  // Every address is consumed; decisions wait for the last one
  always_comb
  begin
    cnt_d = cnt_q;
    own_d = own_q;
    grp_d = grp_q;
    glob_d = glob_q;
    seen_grp_d = seen_grp_q;
    seen_mc_d = seen_mc_q;
    seen3_d = seen3_q;
    viol_d = viol_q;
    done_d = 1'b0;
    ack_d = ack_q;
    test_d = test_q;
    if (i_frame_start)
    begin
      cnt_d = 5'h0;
      own_d = 1'b0;
      grp_d = 1'b0;
      glob_d = 1'b0;
      seen_grp_d = 1'b0;
      seen_mc_d = 1'b0;
      seen3_d = 1'b0;
      viol_d = 1'b0;
      ack_d = 1'b0;
      test_d = 1'b0;
    end
    else if (a_if.vld)
    begin
      if (cnt_q == `LDAC_MAX_ADDR)
        viol_d = 1'b1;
      else
        cnt_d = cnt_q + 5'h1;
      if (own_hit)
        own_d = 1'b1;
      // Group hits only count when the station takes part in groups
      if (a_if.cls == LDAC_CL_GRP && i_grp_enable && i_grp_joined[gidx])
        grp_d = 1'b1;
      if (a_if.cls == LDAC_CL_GLOB)
        glob_d = 1'b1;
      if (a_if.cls == LDAC_CL_GRP)
        seen_grp_d = 1'b1;
      if (is_mc)
        seen_mc_d = 1'b1;
      if (a_if.cls == LDAC_CL_SPEC3)
        seen3_d = 1'b1;
      // Order: nothing unicast after multicast or after special 3
      if (!is_mc && (seen_mc_q || (seen3_q && a_if.cls != LDAC_CL_SPEC3)))
        viol_d = 1'b1;
      if ((a_if.cls == LDAC_CL_GLOB && seen_grp_q) ||
          (a_if.cls == LDAC_CL_GRP && glob_q))
        viol_d = 1'b1;
      if (last_w)
        done_d = 1'b1;
    end
    if (done_q)
    begin
      // Ack only via own individual hit, never for multicast
      ack_d = own_q;
      // Multicast TEST with poll zero answered uncoupled
      test_d = i_is_test_cmd && !i_poll_bit && (grp_q || glob_q) && !own_q;
    end
  end
  // Register stage
  always_ff @(posedge i_clk_sys)
  begin
    if (!i_nrst)
    begin
      cnt_q <= 5'h0;
      own_q <= 1'b0;
      grp_q <= 1'b0;
      glob_q <= 1'b0;
      seen_grp_q <= 1'b0;
      seen_mc_q <= 1'b0;
      seen3_q <= 1'b0;
      viol_q <= 1'b0;
      done_q <= 1'b0;
      ack_q <= 1'b0;
      test_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      own_q <= own_d;
      grp_q <= grp_d;
      glob_q <= glob_d;
      seen_grp_q <= seen_grp_d;
      seen_mc_q <= seen_mc_d;
      seen3_q <= seen3_d;
      viol_q <= viol_d;
      done_q <= done_d;
      ack_q <= ack_d;
      test_q <= test_d;
    end
  end
  // ------------------------------------------------
  // Outputs
  // ------------------------------------------------
  // Flags other than o_done hold until the next frame start; o_done pulses for one cycle
  assign o_done = done_q;
  assign o_own_match = own_q;
  assign o_grp_match = grp_q;
  assign o_glob_match = glob_q;
  assign o_ack_ok = ack_q;
  assign o_test_rsp = test_q;
  assign o_rsp_final = 1'b0;
  assign o_violation = viol_q;
  assign o_addr_cnt = cnt_q;
  // ------------------------------------------------
  // Checks
  // ------------------------------------------------
  // All checks sleep while reset is held
  property p_cnt_cap;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    cnt_q <= `LDAC_MAX_ADDR;
  endproperty
  a_cnt_cap: assert property (p_cnt_cap) else $error("address count above limit");
  property p_over_viol;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (a_if.vld && cnt_q == `LDAC_MAX_ADDR && !i_frame_start) |=> viol_q;
  endproperty
  a_over_viol: assert property (p_over_viol) else $error("17th address not flagged");
  property p_no_mc_ack;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    $rose(ack_q) |-> $past(own_q);
  endproperty
  a_no_mc_ack: assert property (p_no_mc_ack) else $error("ack without own match");
  property p_test_poll;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    test_q |-> !own_q && (grp_q || glob_q);
  endproperty
  a_test_poll: assert property (p_test_poll) else $error("test response without multicast hit");
  property p_mix_viol;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (a_if.vld && a_if.cls == LDAC_CL_GLOB && seen_grp_q && !i_frame_start) |=> viol_q;
  endproperty
  a_mix_viol: assert property (p_mix_viol) else $error("both multicast kinds not flagged");
  property p_order;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (a_if.vld && a_if.cls == LDAC_CL_IND && seen_mc_q && !i_frame_start) |=> viol_q;
  endproperty
  a_order: assert property (p_order) else $error("individual after multicast not flagged");
  property p_own;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (a_if.vld && own_hit && !i_frame_start) |=> own_q;
  endproperty
  a_own: assert property (p_own) else $error("own address missed");
  property p_grp_off;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (a_if.vld && a_if.cls == LDAC_CL_GRP && !i_grp_enable && !grp_q && !i_frame_start) |=> !grp_q;
  endproperty
  a_grp_off: assert property (p_grp_off) else $error("group match with groups disabled");
  property p_done_ack;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (done_q && own_q && !i_frame_start) |=> ack_q;
  endproperty
  a_done_ack: assert property (p_done_ack) else $error("own frame not acknowledged");
  // Counting, framing and order after special 3
  property p_cnt_step;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (a_if.vld && cnt_q != `LDAC_MAX_ADDR && !i_frame_start) |=> cnt_q == $past(cnt_q) + 5'h1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("address count did not step");
  property p_done_pulse;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    done_q |=> !done_q;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("field end held too long");
  property p_ind_after3;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (a_if.vld && a_if.cls == LDAC_CL_IND && seen3_q && !i_frame_start) |=> viol_q;
  endproperty
  a_ind_after3: assert property (p_ind_after3) else $error("individual after special 3 not flagged");
  // Match flags
  property p_glob_flag;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (a_if.vld && a_if.cls == LDAC_CL_GLOB && !i_frame_start) |=> glob_q;
  endproperty
  a_glob_flag: assert property (p_glob_flag) else $error("global address missed");
  property p_grp_hit;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (a_if.vld && a_if.cls == LDAC_CL_GRP && i_grp_enable && i_grp_joined[gidx] && !i_frame_start) |=> grp_q;
  endproperty
  a_grp_hit: assert property (p_grp_hit) else $error("joined group missed");
  // Response decisions
  property p_test_done;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (done_q && i_is_test_cmd && !i_poll_bit && (grp_q || glob_q) && !own_q && !i_frame_start) |=> test_q;
  endproperty
  a_test_done: assert property (p_test_done) else $error("multicast test not answered");
  property p_poll_block;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (done_q && i_poll_bit && !i_frame_start) |=> !test_q;
  endproperty
  a_poll_block: assert property (p_poll_block) else $error("test response with poll set");
  // Per-frame lifetime: flags clear on a new field and otherwise stand
  property p_start_clear;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    i_frame_start |=> cnt_q == 5'h0 && !own_q && !grp_q && !glob_q && !viol_q;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("frame flags not cleared");
  property p_viol_hold;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (viol_q && !i_frame_start) |=> viol_q;
  endproperty
  a_viol_hold: assert property (p_viol_hold) else $error("violation flag dropped");
  property p_ack_hold;
    @(posedge i_clk_sys) disable iff (!i_nrst)
    (ack_q && !done_q && !i_frame_start) |=> ack_q;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack permission dropped");
  // ------------------------------------------------
  // Coverage of the main scenarios
  // ------------------------------------------------
  c_ack: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) $rose(ack_q));
  c_test: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) $rose(test_q));
  c_viol: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) $rose(viol_q));
  c_grp: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) $rose(grp_q));
  c_long_own: cover property (@(posedge i_clk_sys) disable iff (!i_nrst) a_if.vld && own_hit && i_own_long);
endmodule
`default_nettype wire

// File: testbench/ldac_peer_model.sv
// Peer station model that sends destination address octets
`timescale 1ns/100ps
`default_nettype none
module ldac_peer_model
(
  input wire logic i_clk_sys,
  output logic o_frame_start,
  output logic o_oct_vld,
  output logic [7:0] o_oct
);
  logic [7:0] last_oct = 8'h00;

  // Quiet line at time zero
  initial
  begin
    o_frame_start = 1'b0;
    o_oct_vld = 1'b0;
    o_oct = 8'hFF;
  end

  // One slot per falling edge; idle slots show the inverse so stale data never looks valid
  task automatic put(input logic [7:0] b, input bit v);
  begin
    @(negedge i_clk_sys);
    o_frame_start = 1'b0;
    o_oct_vld = v;
    o_oct = v ? b : ~last_oct;
    if (v)
      last_oct = b;
  end
  endtask

  // Frame start, then every address, then one stray octet that must be ignored
  task automatic send(input int n, input logic [31:0] av[20], input bit al[20], input logic [31:0] gaps,
                      input logic [7:0] junk);
    int k;
    int j;
    logic ext;
  begin
    @(negedge i_clk_sys);
    o_frame_start = 1'b1;
    o_oct_vld = 1'b0;
    for (k = 0; k < n; k++)
    begin
      ext = (k == n - 1);
      if (gaps[k])
        put(8'h00, 1'b0);
      if (al[k])
      begin
        put({7'h7E, ext}, 1'b1);
        for (j = 3; j >= 0; j--)
          put(av[k][8 * j +: 8], 1'b1);
      end
      else
        put({av[k][6:0], ext}, 1'b1);
    end
    put(junk, 1'b1);
    put(8'h00, 1'b0);
  end
  endtask
endmodule
`default_nettype wire

// File: testbench/ldac_bench.sv
// Self-checking bench for the destination address classifier
`timescale 1ns/100ps
`default_nettype none
module ldac_bench;
  // ----------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------
  logic i_clk_sys = 1'b0;
  logic i_nrst = 1'b0;
  logic i_frame_start;
  logic i_oct_vld;
  logic [7:0] i_oct;
  logic [31:0] i_own_addr = 32'h00000004;
  logic i_own_long = 1'b0;
  logic i_grp_enable = 1'b1;
  logic [29:0] i_grp_joined = 30'h20000001;
  logic i_is_test_cmd = 1'b0;
  logic i_poll_bit = 1'b0;
  logic o_done, o_own_match, o_grp_match, o_glob_match, o_ack_ok, o_test_rsp, o_rsp_final, o_violation;
  logic [4:0] o_addr_cnt;
  logic [31:0] av[20];
  bit al[20];
  logic [31:0] seed = 32'hE1B8;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  int j, f, n;

  // 20 MHz system clock
  always #25 i_clk_sys = ~i_clk_sys;

  ldac_peer_model peer
  (
    .i_clk_sys(i_clk_sys),
    .o_frame_start(i_frame_start),
    .o_oct_vld(i_oct_vld),
    .o_oct(i_oct)
  );

  ldac_top dut
  (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_frame_start(i_frame_start),
    .i_oct_vld(i_oct_vld),
    .i_oct(i_oct),
    .i_own_addr(i_own_addr),
    .i_own_long(i_own_long),
    .i_grp_enable(i_grp_enable),
    .i_grp_joined(i_grp_joined),
    .i_is_test_cmd(i_is_test_cmd),
    .i_poll_bit(i_poll_bit),
    .o_done(o_done),
    .o_own_match(o_own_match),
    .o_grp_match(o_grp_match),
    .o_glob_match(o_glob_match),
    .o_ack_ok(o_ack_ok),
    .o_test_rsp(o_test_rsp),
    .o_rsp_final(o_rsp_final),
    .o_violation(o_violation),
    .o_addr_cnt(o_addr_cnt)
  );

  // ----------------------------------------
  // Model and checks
  // ----------------------------------------
  // Repeatable random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Four-state compare so an unknown never passes
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t ns: saw %0h, wanted %0h", $time, seen, exp);
    end
  end
  endtask

  task automatic end_sim();
  begin
    $display("Comparisons %0d, mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  // Cycle ceiling cuts a hang short
  always @(posedge i_clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_sim();
    end
  end

  // Expected flags from the address list, then send and compare
  task automatic run(input int n, input logic [31:0] gaps);
    int i, cls;
    bit own, grp, glb, vio, mc, s3, sg, spc;
    logic [6:0] s;
  begin
    {own, grp, glb, vio, mc, s3, sg, spc} = 8'h00;
    for (i = 0; i < n; i++)
    begin
      s = av[i][6:0];
      if (al[i] && av[i] >= 32'h00000080) cls = 3;
      else if (s == 7'h00) cls = 0;
      else if (s < 7'h03) cls = 1;
      else if (s == 7'h03) cls = 2;
      else if (s <= 7'h5F) cls = 3;
      else if (s <= 7'h7D) cls = 4;
      else cls = 5;
      // Addresses past the sixteenth still update the flags; only the count stops
      if (i >= 16) vio = 1'b1;
      if (cls == 3 && (i_own_long ? al[i] && av[i] == i_own_addr : !al[i] && s == i_own_addr[6:0])) own = 1'b1;
      if (cls == 4 && i_grp_enable && i_grp_joined[s - 7'h60]) grp = 1'b1;
      if ((mc && cls <= 3) || (s3 && cls != 2 && cls < 4)) vio = 1'b1;
      if ((cls == 4 && glb) || (cls == 5 && sg)) vio = 1'b1;
      glb |= cls == 5;
      sg |= cls == 4;
      mc |= cls >= 4;
      s3 |= cls == 2;
      spc |= cls == 1 || cls == 2;
    end
    peer.send(n, av, al, gaps, {i_own_addr[6:0], 1'b1});
    i = 0;
    while (o_done !== 1'b1 && i < 40)
    begin
      @(negedge i_clk_sys);
      i++;
    end
    chk(o_done, 1);
    chk(o_own_match, own);
    chk(o_grp_match, grp);
    chk(o_glob_match, glb);
    chk(o_violation, vio);
    chk(o_addr_cnt, n > 16 ? 16 : n);
    @(negedge i_clk_sys);
    chk(o_done, 0);
    chk(o_own_match, own);
    chk(o_rsp_final, 0);
    if (!vio && !spc) chk(o_ack_ok, own);
    if (!vio) chk(o_test_rsp, i_is_test_cmd && !i_poll_bit && (grp || glb) && !own);
  end
  endtask

  // Short-format frame, address k in byte k of v
  task automatic sf(input int n, input logic [127:0] v, input bit tst, input bit poll);
    int k;
  begin
    for (k = 0; k < n; k++)
    begin
      av[k] = {25'h0, v[8 * k +: 7]};
      al[k] = 1'b0;
    end
    i_is_test_cmd = tst;
    i_poll_bit = poll;
    run(n, 32'h00000002);
  end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk({o_done, o_own_match, o_grp_match, o_glob_match, o_ack_ok, o_test_rsp, o_violation, o_addr_cnt}, 0);
    i_nrst = 1'b1;
    sf(1, 128'h04, 1'b0, 1'b0);
    i_own_addr = 32'h0000005F;
    for (j = 0; j < 17; j++)
    begin
      av[j] = 32'h50 + j;
      al[j] = 1'b0;
    end
    run(16, 32'h0000AAAA);
    run(17, 32'h00000000);
    i_own_addr = 32'h00000004;
    sf(2, 128'h7D60, 1'b1, 1'b0);
    sf(2, 128'h7D60, 1'b1, 1'b1);
    sf(2, 128'h7F05, 1'b1, 1'b0);
    sf(2, 128'h0400, 1'b0, 1'b0);
    sf(2, 128'h0460, 1'b0, 1'b0);
    sf(2, 128'h7F60, 1'b0, 1'b0);
    sf(2, 128'h0103, 1'b0, 1'b0);
    sf(4, 128'h60030104, 1'b1, 1'b0);
    i_grp_enable = 1'b0;
    sf(2, 128'h6104, 1'b0, 1'b0);
    sf(1, 128'h60, 1'b1, 1'b0);
    i_grp_enable = 1'b1;
    i_own_long = 1'b1;
    i_own_addr = 32'h00012345;
    av[0] = 32'h00000080;
    av[1] = 32'h00012345;
    av[2] = 32'h0000007F;
    for (j = 0; j < 3; j++)
      al[j] = 1'b1;
    run(3, 32'h00000005);
    i_own_long = 1'b0;
    // Random mixed frames; individual values stay distinct within a frame
    for (f = 0; f < 40; f++)
    begin
      seed = lfsr(seed);
      n = 1 + seed[3:0];
      i_own_addr = 32'h4 + 5 * seed[7:4];
      i_grp_enable = seed[8];
      i_is_test_cmd = seed[9];
      i_poll_bit = seed[10];
      i_grp_joined = seed[31:2];
      for (j = 0; j < n; j++)
      begin
        seed = lfsr(seed);
        av[j] = seed[1:0] == 2'h0 ? 32'h60 + seed[6:2] % 30 : 32'h4 + 5 * j + seed[2];
        al[j] = 1'b0;
      end
      seed = lfsr(seed);
      run(n, seed);
    end
    end_sim();
  end
endmodule
`default_nettype wire
